// [verilog/uam_pkg.sv]
// shared constants, register map and types of the asynchronous serial port
// assumes one oscillator-rate clock and a plain strobe-based register port
package uam_pkg;

    // register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_SERIAL_BUFFER = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_SERIAL_CONTROL = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_POWER_CONTROL = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_BAUD_SOURCE = 4'h3;

    // serial_control bit positions
    localparam int CTL_MODE_HI = 7;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_FILTER = 5;
    localparam int CTL_RX_ENABLE = 4;
    localparam int CTL_TX_NINTH = 3;
    localparam int CTL_RX_NINTH = 2;
    localparam int CTL_TX_DONE = 1;
    localparam int CTL_RX_DONE = 0;

    // power_control and baud_source bit positions
    localparam int PWR_BAUD_DOUBLE = 7;
    localparam int SRC_TX_TIMER = 0;
    localparam int SRC_RX_TIMER = 1;

    // reset values
    localparam logic [DATA_W-1:0] BUFFER_RST = 8'h00;
    localparam logic RESET_BIT = 1'h0;

    // oscillator prescaler moduli giving the 16x tick
    localparam logic [3:0] DIV_MODE0 = 4'hC;
    localparam logic [3:0] DIV_FIXED_SLOW = 4'h4;
    localparam logic [3:0] DIV_FIXED_FAST = 4'h2;
    localparam logic [3:0] PSC_ZERO = 4'h0;
    localparam logic [3:0] PSC_STEP = 4'h1;

    // divide-by-16 bit-time counter
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_STEP = 4'h1;
    localparam logic [3:0] CNT_LAST = 4'hF;
    localparam logic [3:0] SAMPLE_A = 4'h7;
    localparam logic [3:0] SAMPLE_B = 4'h8;
    localparam logic [3:0] SAMPLE_C = 4'h9;

    // shift register patterns
    localparam logic [8:0] RX_FILL = 9'h1FF;
    localparam logic [8:0] TX_LAST = 9'h001;
    localparam logic [9:0] TX_CLEAR = 10'h000;

    typedef enum logic [1:0] {
        MODE_SHIFT = 2'h0,
        MODE_VAR8 = 2'h1,
        MODE_FIX9 = 2'h2,
        MODE_VAR9 = 2'h3
    } uam_mode_t;

    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_WAIT = 4'b0010,
        TX_START = 4'b0100,
        TX_DATA = 4'b1000
    } uam_tx_state_t;

    typedef enum logic [2:0] {
        RX_HUNT = 3'b001,
        RX_RECV = 3'b010,
        RX_HOLD = 3'b100
    } uam_rx_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } uam_bus_req_t;

endpackage

// [verilog/uam_core.sv]
// asynchronous serial port: 10-bit and 11-bit frames, full duplex
// assumes synchronous pin inputs, timer overflow pulses one cycle wide,
// and a register master that never issues read and write together
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps

module uam_core (
    // clock, reset, enable
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    // register port
    input wire uam_pkg::uam_bus_req_t bus_req,
    output logic [uam_pkg::DATA_W-1:0] rd_data,
    // baud sources
    input wire logic timer1_ovf,
    input wire logic timer2_ovf,
    // serial pins
    input wire logic rx_line,
    output logic tx_line,
    // flags
    output logic tx_done_flag,
    output logic rx_done_flag
);

    logic mode_sel_hi;
    logic mode_sel_lo;
    logic multiproc_filter;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic baud_double;
    logic tx_timer_select;
    logic rx_timer_select;
    logic [uam_pkg::DATA_W-1:0] serial_buffer;

    logic wr_buffer;
    logic wr_control;
    logic wr_power;
    logic wr_source;
    logic [uam_pkg::DATA_W-1:0] next_rd_data;

    uam_pkg::uam_mode_t mode;
    logic async_mode;
    logic nine_bit;

    logic [3:0] psc;
    logic [3:0] psc_mod;
    logic osc_tick;
    logic t1_half;
    logic t1_tick;
    logic tx_tick;
    logic rx_tick;

    uam_pkg::uam_tx_state_t tx_state;
    logic [3:0] tx_cnt;
    logic tx_roll;
    logic [9:0] tx_sr;
    logic tx_first;
    logic tx_set;

    uam_pkg::uam_rx_state_t rx_state;
    logic [3:0] rx_cnt;
    logic [8:0] rx_sr;
    logic rx_prev;
    logic samp_a;
    logic samp_b;
    logic rx_bit;
    logic rx_fall;
    logic rx_accept;
    logic rx_load;

    function automatic logic [7:0] uam_reverse(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction

    assign mode = uam_pkg::uam_mode_t'({mode_sel_hi, mode_sel_lo});
    assign async_mode = (mode != uam_pkg::MODE_SHIFT);
    assign nine_bit = (mode == uam_pkg::MODE_FIX9) || (mode == uam_pkg::MODE_VAR9);

    // address decode
    always_comb begin
        wr_buffer = 1'b0;
        wr_control = 1'b0;
        wr_power = 1'b0;
        wr_source = 1'b0;
        if (bus_req.addr == uam_pkg::ADDR_SERIAL_BUFFER) begin
            wr_buffer = bus_req.wr;
        end else if (bus_req.addr == uam_pkg::ADDR_SERIAL_CONTROL) begin
            wr_control = bus_req.wr;
        end else if (bus_req.addr == uam_pkg::ADDR_POWER_CONTROL) begin
            wr_power = bus_req.wr;
        end else if (bus_req.addr == uam_pkg::ADDR_BAUD_SOURCE) begin
            wr_source = bus_req.wr;
        end
    end

    always_comb begin
        next_rd_data = '0;
        if (bus_req.addr == uam_pkg::ADDR_SERIAL_BUFFER) begin
            next_rd_data = serial_buffer;
        end else if (bus_req.addr == uam_pkg::ADDR_SERIAL_CONTROL) begin
            next_rd_data[uam_pkg::CTL_MODE_HI] = mode_sel_hi;
            next_rd_data[uam_pkg::CTL_MODE_LO] = mode_sel_lo;
            next_rd_data[uam_pkg::CTL_FILTER] = multiproc_filter;
            next_rd_data[uam_pkg::CTL_RX_ENABLE] = rx_enable;
            next_rd_data[uam_pkg::CTL_TX_NINTH] = tx_ninth_bit;
            next_rd_data[uam_pkg::CTL_RX_NINTH] = rx_ninth_bit;
            next_rd_data[uam_pkg::CTL_TX_DONE] = tx_done_flag;
            next_rd_data[uam_pkg::CTL_RX_DONE] = rx_done_flag;
        end else if (bus_req.addr == uam_pkg::ADDR_POWER_CONTROL) begin
            next_rd_data[uam_pkg::PWR_BAUD_DOUBLE] = baud_double;
        end else if (bus_req.addr == uam_pkg::ADDR_BAUD_SOURCE) begin
            next_rd_data[uam_pkg::SRC_TX_TIMER] = tx_timer_select;
            next_rd_data[uam_pkg::SRC_RX_TIMER] = rx_timer_select;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rd_data <= '0;
        end else if (clk_en) begin
            if (bus_req.rd) begin
                rd_data <= next_rd_data;
            end else begin
                rd_data <= '0;
            end
        end
    end

    // plain software-owned control bits
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mode_sel_hi <= uam_pkg::RESET_BIT;
            mode_sel_lo <= uam_pkg::RESET_BIT;
            multiproc_filter <= uam_pkg::RESET_BIT;
            rx_enable <= uam_pkg::RESET_BIT;
            tx_ninth_bit <= uam_pkg::RESET_BIT;
            baud_double <= uam_pkg::RESET_BIT;
            tx_timer_select <= uam_pkg::RESET_BIT;
            rx_timer_select <= uam_pkg::RESET_BIT;
        end else if (clk_en) begin
            if (wr_control) begin
                mode_sel_hi <= bus_req.wdata[uam_pkg::CTL_MODE_HI];
                mode_sel_lo <= bus_req.wdata[uam_pkg::CTL_MODE_LO];
                multiproc_filter <= bus_req.wdata[uam_pkg::CTL_FILTER];
                rx_enable <= bus_req.wdata[uam_pkg::CTL_RX_ENABLE];
                tx_ninth_bit <= bus_req.wdata[uam_pkg::CTL_TX_NINTH];
            end
            if (wr_power) begin
                baud_double <= bus_req.wdata[uam_pkg::PWR_BAUD_DOUBLE];
            end
            if (wr_source) begin
                tx_timer_select <= bus_req.wdata[uam_pkg::SRC_TX_TIMER];
                rx_timer_select <= bus_req.wdata[uam_pkg::SRC_RX_TIMER];
            end
        end
    end

    // hardware-set flags: a set in the same cycle as a software write wins
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tx_done_flag <= uam_pkg::RESET_BIT;
        end else if (clk_en) begin
            if (tx_set) begin
                tx_done_flag <= 1'b1;
            end else if (wr_control) begin
                tx_done_flag <= bus_req.wdata[uam_pkg::CTL_TX_DONE];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rx_done_flag <= uam_pkg::RESET_BIT;
            rx_ninth_bit <= uam_pkg::RESET_BIT;
            serial_buffer <= uam_pkg::BUFFER_RST;
        end else if (clk_en) begin
            if (rx_load) begin
                rx_done_flag <= 1'b1;
                rx_ninth_bit <= rx_bit;
                serial_buffer <= uam_reverse(rx_sr[7:0]);
            end else if (wr_control) begin
                rx_done_flag <= bus_req.wdata[uam_pkg::CTL_RX_DONE];
                rx_ninth_bit <= bus_req.wdata[uam_pkg::CTL_RX_NINTH];
            end
        end
    end

    // 16x tick generation
    always_comb begin
        if (mode == uam_pkg::MODE_SHIFT) begin
            psc_mod = uam_pkg::DIV_MODE0;
        end else if (baud_double) begin
            psc_mod = uam_pkg::DIV_FIXED_FAST;
        end else begin
            psc_mod = uam_pkg::DIV_FIXED_SLOW;
        end
    end

    assign osc_tick = (psc == psc_mod - uam_pkg::PSC_STEP);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            psc <= uam_pkg::PSC_ZERO;
        end else if (clk_en) begin
            // a modulus change mid-count can overshoot; the wrap guard recovers it
            if (osc_tick || psc >= psc_mod) begin
                psc <= uam_pkg::PSC_ZERO;
            end else begin
                psc <= psc + uam_pkg::PSC_STEP;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            t1_half <= uam_pkg::RESET_BIT;
        end else if (clk_en && timer1_ovf) begin
            t1_half <= !t1_half;
        end
    end

    // without doubling, every second timer 1 overflow makes one 16x tick
    assign t1_tick = timer1_ovf && (baud_double || t1_half);
    assign tx_tick = (mode == uam_pkg::MODE_FIX9) ? osc_tick :
                     (tx_timer_select ? timer2_ovf : t1_tick);
    assign rx_tick = (mode == uam_pkg::MODE_FIX9) ? osc_tick :
                     (rx_timer_select ? timer2_ovf : t1_tick);

    // transmitter bit-time counter runs free
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tx_cnt <= uam_pkg::CNT_ZERO;
        end else if (clk_en && tx_tick) begin
            tx_cnt <= tx_cnt + uam_pkg::CNT_STEP;
        end
    end

    assign tx_roll = tx_tick && (tx_cnt == uam_pkg::CNT_LAST);

    // transmitter; a new buffer write in an asynchronous mode restarts any frame in flight
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tx_state <= uam_pkg::TX_IDLE;
            tx_sr <= uam_pkg::TX_CLEAR;
            tx_first <= 1'b0;
            tx_line <= 1'b1;
            tx_set <= 1'b0;
        end else if (clk_en) begin
            tx_set <= 1'b0;
            if (wr_buffer && async_mode) begin
                tx_sr <= {1'b0, (nine_bit ? tx_ninth_bit : 1'b1), bus_req.wdata};
                tx_state <= uam_pkg::TX_WAIT;
                tx_line <= 1'b1;
            end else if (tx_roll) begin
                case (tx_state)
                    uam_pkg::TX_WAIT: begin
                        tx_state <= uam_pkg::TX_START;
                        tx_line <= 1'b0;
                    end
                    uam_pkg::TX_START: begin
                        tx_state <= uam_pkg::TX_DATA;
                        tx_line <= tx_sr[0];
                        tx_first <= 1'b1;
                    end
                    uam_pkg::TX_DATA: begin
                        if (!tx_first && tx_sr[9:1] == uam_pkg::TX_LAST) begin
                            tx_sr <= {1'b0, tx_sr[9:1]};
                            tx_line <= 1'b1;
                            tx_state <= uam_pkg::TX_IDLE;
                            tx_set <= 1'b1;
                        end else begin
                            // stop enters just left of the ninth bit, so no stray zero follows it
                            tx_sr <= {1'b0, tx_sr[9] | (tx_first && nine_bit), tx_sr[8:1]};
                            tx_line <= tx_sr[1];
                            tx_first <= 1'b0;
                        end
                    end
                    default: begin
                        tx_line <= 1'b1;
                    end
                endcase
            end
        end
    end

    // receiver
    assign rx_fall = rx_tick && rx_prev && !rx_line;
    assign rx_bit = (samp_a & samp_b) | (samp_a & rx_line) | (samp_b & rx_line);
    assign rx_accept = !rx_done_flag && (!multiproc_filter || rx_bit);
    assign rx_load = (rx_state == uam_pkg::RX_RECV) && rx_tick && (rx_cnt == uam_pkg::SAMPLE_C) &&
                     !rx_sr[8] && rx_accept;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rx_prev <= 1'b1;
        end else if (clk_en && rx_tick) begin
            rx_prev <= rx_line;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            samp_a <= 1'b1;
            samp_b <= 1'b1;
        end else if (clk_en && rx_tick) begin
            if (rx_cnt == uam_pkg::SAMPLE_A) begin
                samp_a <= rx_line;
            end
            if (rx_cnt == uam_pkg::SAMPLE_B) begin
                samp_b <= rx_line;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rx_state <= uam_pkg::RX_HUNT;
            rx_cnt <= uam_pkg::CNT_ZERO;
            rx_sr <= uam_pkg::RX_FILL;
        end else if (clk_en) begin
            case (rx_state)
                uam_pkg::RX_HUNT: begin
                    if (rx_fall && rx_enable && async_mode) begin
                        rx_sr <= uam_pkg::RX_FILL;
                        rx_cnt <= uam_pkg::CNT_ZERO;
                        rx_state <= uam_pkg::RX_RECV;
                    end
                end
                uam_pkg::RX_RECV: begin
                    if (rx_tick) begin
                        rx_cnt <= rx_cnt + uam_pkg::CNT_STEP;
                        if (rx_cnt == uam_pkg::SAMPLE_C) begin
                            if (rx_sr == uam_pkg::RX_FILL && rx_bit) begin
                                rx_state <= uam_pkg::RX_HUNT;
                            end else if (!rx_sr[8]) begin
                                rx_sr <= {rx_sr[7:0], rx_bit};
                                // mode 1 hunts at once; 9-bit modes wait out the stop bit
                                rx_state <= nine_bit ? uam_pkg::RX_HOLD : uam_pkg::RX_HUNT;
                            end else begin
                                rx_sr <= {rx_sr[7:0], rx_bit};
                            end
                        end
                    end
                end
                uam_pkg::RX_HOLD: begin
                    if (rx_tick) begin
                        rx_cnt <= rx_cnt + uam_pkg::CNT_STEP;
                        if (rx_cnt == uam_pkg::SAMPLE_C) begin
                            rx_state <= uam_pkg::RX_HUNT;
                        end
                    end
                end
                default: begin
                    rx_state <= uam_pkg::RX_HUNT;
                end
            endcase
        end
    end

endmodule

// [bench/uam_core_monitor.sv]
// checker for the serial port core, bound to every instance
// assumes one clock domain with synchronous active-low reset
`timescale 1ns/1ps

module uam_core_monitor (
    // clock, reset, enable
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    // register port
    input wire uam_pkg::uam_bus_req_t bus_req,
    input wire logic [uam_pkg::DATA_W-1:0] rd_data,
    // baud sources
    input wire logic timer1_ovf,
    input wire logic timer2_ovf,
    // pins and flags
    input wire logic rx_line,
    input wire logic tx_line,
    input wire logic tx_done_flag,
    input wire logic rx_done_flag
);
    default clocking mon_cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    logic ctl_wr;
    logic ctl_rd;
    logic buf_wr;
    logic clr_tx;
    logic clr_rx;
    logic [1:0] mode_q;
    logic ren_q;
    assign ctl_wr = clk_en && bus_req.wr && bus_req.addr == uam_pkg::ADDR_SERIAL_CONTROL;
    assign ctl_rd = clk_en && bus_req.rd && bus_req.addr == uam_pkg::ADDR_SERIAL_CONTROL;
    assign buf_wr = clk_en && bus_req.wr && bus_req.addr == uam_pkg::ADDR_SERIAL_BUFFER;
    assign clr_tx = ctl_wr && !bus_req.wdata[uam_pkg::CTL_TX_DONE];
    assign clr_rx = ctl_wr && !bus_req.wdata[uam_pkg::CTL_RX_DONE];

    // shadow of what software last wrote, so mode-dependent checks need no design internals
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mode_q <= 2'h0;
            ren_q <= 1'h0;
        end else if (ctl_wr) begin
            mode_q <= bus_req.wdata[7:6];
            ren_q <= bus_req.wdata[uam_pkg::CTL_RX_ENABLE];
        end
    end

    a_rd_idle_zero: assert property ($past(clk_en) && !$past(bus_req.rd) |-> rd_data == 8'h00)
        else $error("read data not zero outside a read answer");
    a_unmapped_zero: assert property (clk_en && bus_req.rd && bus_req.addr > 4'h3 |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_ctl_readback: assert property (ctl_rd |=> rd_data[7:6] == mode_q && rd_data[4] == ren_q)
        else $error("control readback wrong");
    a_mode0_quiet: assert property (buf_wr && mode_q == 2'h0 |=> tx_line [*8])
        else $error("shift mode drove the serial output");
    a_tx_start_due: assert property (buf_wr && mode_q != 2'h0 && tx_line |-> ##[1:80] !tx_line)
        else $error("start bit missing after buffer write");
    a_tx_low_width: assert property ($fell(tx_line) |-> !tx_line [*8])
        else $error("low bit shorter than a bit time");
    a_tx_done_line: assert property ($rose(tx_done_flag) |-> tx_line && $past(tx_line))
        else $error("transmit done without stop level");
    a_tx_done_sticky: assert property ($fell(tx_done_flag) |-> $past(clr_tx))
        else $error("transmit done cleared without software");
    a_rx_done_sticky: assert property ($fell(rx_done_flag) |-> $past(clr_rx))
        else $error("receive done cleared without software");
    a_rx_enabled: assert property ($rose(rx_done_flag) |-> $past(ren_q) && $past(mode_q) != 2'h0)
        else $error("receive done while reception disabled");

    c_tx_done: cover property ($rose(tx_done_flag));
    c_rx_done: cover property ($rose(rx_done_flag));
    c_ctl_read: cover property (ctl_rd);
endmodule

bind uam_core uam_core_monitor mon_u (.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .bus_req(bus_req),
    .rd_data(rd_data), .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf), .rx_line(rx_line),
    .tx_line(tx_line), .tx_done_flag(tx_done_flag), .rx_done_flag(rx_done_flag));

// [bench/uam_remote_node.sv]
// far-side serial node: sends frames into the core and decodes its output
// assumes the bench gives the bit time in clock cycles for the chosen rate
`timescale 1ns/1ps

module uam_remote_node (
    // clock
    input wire logic clock,
    // serial pins seen from the far side
    input wire logic tx_line,
    output logic rx_line
);
    // mark level between frames
    initial rx_line = 1'h1;

    // bits[0] leaves first; a glitch is a one-bit frame of short width
    task automatic send(input logic [10:0] bits, input int nbits, input int period);
        for (int i = 0; i < nbits; i++) begin
            rx_line <= bits[i];
            repeat (period) @(posedge clock);
        end
        rx_line <= 1'h1;
    endtask

    // samples mid-bit from the start edge; a missing frame leaves ok low
    task automatic capture(input int nbits, input int period, output logic [10:0] bits, output bit ok);
        int n;
        bits = '0;
        for (n = 0; n < 4000 && tx_line !== 1'h0; n++) begin
            @(posedge clock);
        end
        ok = (n < 4000);
        repeat (period / 2) @(posedge clock);
        for (int i = 0; i < nbits; i++) begin
            bits[i] = tx_line;
            repeat (period) @(posedge clock);
        end
    endtask
endmodule

// [bench/tb_top.sv]
// top bench: register tasks, far-side node and frame scenarios
// assumes the core carries its bound checker; timers overflow freely
`timescale 1ns/1ps

module tb_top;
    logic clock = 1'h0;
    logic rst_b = 1'h0;
    logic clk_en = 1'h1;
    uam_pkg::uam_bus_req_t bus_req = '0;
    logic [uam_pkg::DATA_W-1:0] rd_data;
    logic timer1_ovf = 1'h0;
    logic timer2_ovf = 1'h0;
    logic [1:0] t2_cnt = 2'h0;
    logic rx_line;
    logic tx_line;
    logic tx_done_flag;
    logic rx_done_flag;
    int bad_count = 0;
    int checked = 0;

    always #25 clock = ~clock;

    // timer 1 overflows every 2 cycles, timer 2 every 3
    always @(posedge clock) begin
        timer1_ovf <= ~timer1_ovf;
        t2_cnt <= (t2_cnt == 2'h2) ? 2'h0 : t2_cnt + 2'h1;
        timer2_ovf <= (t2_cnt == 2'h2);
    end

    uam_core dut_u (.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .bus_req(bus_req), .rd_data(rd_data),
        .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf), .rx_line(rx_line), .tx_line(tx_line),
        .tx_done_flag(tx_done_flag), .rx_done_flag(rx_done_flag));
    uam_remote_node remote_u (.clock(clock), .tx_line(tx_line), .rx_line(rx_line));

    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'h1;
        @(posedge clock);
        bus_req.wr <= 1'h0;
        @(posedge clock);
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        bus_req.addr <= a;
        bus_req.rd <= 1'h1;
        @(posedge clock);
        bus_req.rd <= 1'h0;
        #1 d = rd_data;
        @(posedge clock);
    endtask

    task automatic rx_case(input logic [7:0] c, input logic [10:0] f, input int n, input int p,
            input logic flag, input logic [7:0] buf_exp);
        logic [7:0] v;
        reg_wr(uam_pkg::ADDR_SERIAL_CONTROL, c);
        remote_u.send(f, n, p);
        repeat (p) @(posedge clock);
        check(rx_done_flag, flag);
        reg_rd(uam_pkg::ADDR_SERIAL_BUFFER, v);
        check(v, buf_exp);
    endtask

    initial begin
        logic [7:0] v;
        logic [7:0] d;
        logic [7:0] r;
        logic [10:0] fr;
        logic [10:0] rf;
        logic nin;
        bit ok;
        static logic [7:0] ctl [4] = '{8'h98, 8'h98, 8'h50, 8'hD0};
        static logic [7:0] pwr [4] = '{8'h80, 8'h00, 8'h00, 8'h00};
        static logic [7:0] src [4] = '{8'h00, 8'h00, 8'h03, 8'h00};
        static int per [4] = '{32, 64, 48, 64};
        static int nb [4] = '{11, 11, 10, 11};
        repeat (16) @(posedge clock);
        rst_b <= 1'h1;
        @(posedge clock);
        for (int a = 0; a < 6; a++) begin
            reg_rd(4'(a), v);
            check(v, 11'h0);
        end
        check({tx_line, tx_done_flag, rx_done_flag}, 11'h4);
        reg_wr(uam_pkg::ADDR_SERIAL_BUFFER, 8'h55);
        repeat (100) @(posedge clock);
        check(tx_line, 1'h1);
        clk_en <= 1'h0;
        reg_wr(uam_pkg::ADDR_POWER_CONTROL, 8'h80);
        clk_en <= 1'h1;
        reg_rd(uam_pkg::ADDR_POWER_CONTROL, v);
        check(v, 11'h0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            d = 8'hA5 ^ 8'(i);
            r = 8'h3C + 8'(i);
            nin = i[0];
            rf = (nb[i] == 11) ? {1'b1, nin, r, 1'b0} : {2'b01, r, 1'b0};
            reg_wr(uam_pkg::ADDR_POWER_CONTROL, pwr[i]);
            reg_wr(uam_pkg::ADDR_BAUD_SOURCE, src[i]);
            reg_wr(uam_pkg::ADDR_SERIAL_CONTROL, ctl[i]);
            reg_rd(uam_pkg::ADDR_BAUD_SOURCE, v);
            check(v, src[i]);
            fork
                remote_u.capture(nb[i], per[i], fr, ok);
                remote_u.send(rf, nb[i], per[i]);
                reg_wr(uam_pkg::ADDR_SERIAL_BUFFER, d);
            join
            check(ok, 1'h1);
            check(fr, (nb[i] == 11) ? {1'b1, ctl[i][3], d, 1'b0} : {2'b01, d, 1'b0});
            repeat (per[i]) @(posedge clock);
            reg_rd(uam_pkg::ADDR_SERIAL_CONTROL, v);
            check(v, {ctl[i][7:3], (nb[i] == 11) ? nin : 1'b1, 2'b11});
            reg_rd(uam_pkg::ADDR_SERIAL_BUFFER, v);
            check(v, r);
            reg_wr(uam_pkg::ADDR_SERIAL_CONTROL, ctl[i]);
            check(tx_done_flag, 1'h0);
            $display("test frame config %0d done", i);
        end
        reg_wr(uam_pkg::ADDR_POWER_CONTROL, 8'h80);
        rx_case(8'h98, {2'b11, 8'h11, 1'b0}, 11, 32, 1'h1, 8'h11);
        rx_case(8'h99, {2'b11, 8'h22, 1'b0}, 11, 32, 1'h1, 8'h11);
        rx_case(8'hB8, {2'b10, 8'h33, 1'b0}, 11, 32, 1'h0, 8'h11);
        remote_u.send(11'h0, 1, 4);
        // let the false start be judged and rejected before the real frame begins
        repeat (32) @(posedge clock);
        rx_case(8'hB8, {2'b01, 8'h44, 1'b0}, 11, 32, 1'h1, 8'h44);
        rx_case(8'h88, {2'b11, 8'h55, 1'b0}, 11, 32, 1'h0, 8'h44);
        reg_wr(uam_pkg::ADDR_BAUD_SOURCE, 8'h03);
        rx_case(8'h70, {2'b00, 8'h66, 1'b0}, 10, 48, 1'h0, 8'h44);
        rx_case(8'h50, {2'b00, 8'h77, 1'b0}, 10, 48, 1'h1, 8'h77);
        $display("test receive filters done");
        end_sim();
    end

    // a hang anywhere counts as a mismatch
    initial begin
        repeat (100000) @(posedge clock);
        bad_count++;
        end_sim();
    end
endmodule
